/* logic/hpp_pkg.sv */
// package: register map, field layout, reset values and timing for port power control
`default_nettype none
package hpp_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_PWR_EN     = 12'h000;
   localparam logic [11:0] OFS_MODE       = 12'h004;
   localparam logic [11:0] OFS_CHG_EN     = 12'h008;
   localparam logic [11:0] OFS_MIN_WIDTH  = 12'h00C;
   localparam logic [11:0] OFS_INACTIVE   = 12'h010;
   localparam logic [11:0] OFS_LOCKOUT    = 12'h014;
   localparam logic [11:0] OFS_OC_STATUS  = 12'h018;
   localparam logic [11:0] OFS_PIN_STATE  = 12'h01C;
   // ----------------------------------------------------------------
   // fields and widths
   // ----------------------------------------------------------------
   localparam int MODE_GANG_BIT  = 0;
   localparam int MODE_LOCK_BIT  = 1;
   localparam int MIN_WIDTH_W    = 4;
   localparam int INACTIVE_W     = 8;
   localparam int LOCKOUT_W      = 8;
   localparam logic [3:0] MIN_WIDTH_MAX = 4'h5;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] RST_MIN_WIDTH = 4'h1;
   localparam logic [7:0] RST_INACTIVE  = 8'h14;
   localparam logic [7:0] RST_LOCKOUT   = 8'h0A;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ     = 40_000_000;
   localparam int TICK_MS    = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
endpackage
`default_nettype wire

/* logic/hpp_port_power.sv */
// port power control and overcurrent detection with AHB-Lite register slave
// Operation
// RL1: one shared pin powers and senses port
// RL2: ganged uses one pin, individual per-port
// RL3: ganged overcurrent flags every port
// RL4: ganged selected only by configuration
// RL5: individual mode after reset
// RL6: power off drives low, pull-up off
// RL7: power on releases driver, enables pull-up
// RL8: external switch pulls pin low on fault
// RL9: sample and filter pin while enabled
// RL10: continuous low for single width reports
// RL11: two low groups within window report
// RL12: per-port charging supply indication
// RL13: charging acknowledged, no current supplied
// RL14: single width 4-bit, 0 to 5 ms
// RL15: double window 8-bit, default 20 ms
// RL16: lockout after power on ignores pin
// RL17: two-flop synchroniser before pulse counters
//
// The AHB-Lite slave port and the address map were decided locally.
`default_nettype none
module hpp_port_power #(
   parameter int NPORTS      = 6,
   parameter int TICK_CYCLES = hpp_pkg::TICK_CYCLES
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output var  logic [31:0]       hrdata,
   output var  logic              hreadyout,
   output var  logic              hresp,
   input  wire logic [NPORTS-1:0] port_ctl_pin_i,
   output var  logic [NPORTS-1:0] port_ctl_pin_o,
   output var  logic [NPORTS-1:0] port_ctl_pin_oe_n,
   output var  logic [NPORTS-1:0] port_ctl_pullup_en,
   input  wire logic              shared_power_pin_i,
   output var  logic              shared_power_pin_o,
   output var  logic              shared_power_pin_oe_n,
   output var  logic              shared_power_pullup_en,
   output var  logic [NPORTS-1:0] chg_ack,
   output var  logic [NPORTS-1:0] oc_flag
);
   // enables and status of all ports share one 32-bit register word
   if (NPORTS < 1 || NPORTS > 32) begin : g_bad_nports
      $error("NPORTS must be 1..32");
   end
   if (TICK_CYCLES < 1) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 1");
   end

   localparam int TW = $clog2(TICK_CYCLES + 1);

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------
   logic        wr_pend_ff;
   logic [11:0] wr_addr_ff;
   wire  logic  addr_phase = hsel & htrans[1] & hready;
   // writes land at the end of their data phase, when hwdata stands
   wire  logic  wr_now     = wr_pend_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 12'h000;
      end else begin
         wr_pend_ff <= addr_phase & hwrite;
         wr_addr_ff <= haddr[11:0];
      end
   end

   logic [NPORTS-1:0] pwr_en_ff;
   logic [NPORTS-1:0] chg_en_ff;
   logic              gang_ff;
   logic              gang_d_ff;
   logic              mode_lock_ff;
   logic [3:0]        min_width_ff;
   logic [7:0]        inactive_ff;
   logic [7:0]        lockout_ff;
   logic [NPORTS-1:0] oc_stat_ff;

   wire logic wr_pwr   = wr_now && wr_addr_ff == hpp_pkg::OFS_PWR_EN;
   wire logic wr_mode  = wr_now && wr_addr_ff == hpp_pkg::OFS_MODE;
   wire logic wr_chg   = wr_now && wr_addr_ff == hpp_pkg::OFS_CHG_EN;
   wire logic wr_minw  = wr_now && wr_addr_ff == hpp_pkg::OFS_MIN_WIDTH;
   wire logic wr_inact = wr_now && wr_addr_ff == hpp_pkg::OFS_INACTIVE;
   wire logic wr_lock  = wr_now && wr_addr_ff == hpp_pkg::OFS_LOCKOUT;
   wire logic wr_ocst  = wr_now && wr_addr_ff == hpp_pkg::OFS_OC_STATUS;

   // out-of-range widths saturate at the top legal value
   wire logic [3:0] minw_in   = (hwdata[3:0] > hpp_pkg::MIN_WIDTH_MAX) ?
                                hpp_pkg::MIN_WIDTH_MAX : hwdata[3:0];
   // zero is illegal for both timers; held at one step
   wire logic [7:0] tmr_in    = (hwdata[7:0] == 8'h00) ? 8'h01 : hwdata[7:0];
   // mode is configuration only: writable until the lock bit is set
   wire logic       mode_open = wr_mode && !mode_lock_ff;

   // next values; the read mux decodes these, so a read right behind
   // a write on the pipelined bus already returns the new word
   wire logic [NPORTS-1:0] nxt_pwr_en    = wr_pwr ? hwdata[NPORTS-1:0] : pwr_en_ff;
   wire logic [NPORTS-1:0] nxt_chg_en    = wr_chg ? hwdata[NPORTS-1:0] : chg_en_ff; // RL12
   wire logic              nxt_gang      = mode_open ?
                                           hwdata[hpp_pkg::MODE_GANG_BIT] : gang_ff;  // RL4
   wire logic              nxt_mode_lock = mode_open ?
                                           hwdata[hpp_pkg::MODE_LOCK_BIT] : mode_lock_ff;
   wire logic [3:0]        nxt_min_width = wr_minw ? minw_in : min_width_ff;          // RL14
   wire logic [7:0]        nxt_inactive  = wr_inact ? tmr_in : inactive_ff;           // RL15
   wire logic [7:0]        nxt_lockout   = wr_lock ? tmr_in : lockout_ff;             // RL16

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwr_en_ff    <= '0;
         chg_en_ff    <= '0;
         gang_ff      <= 1'b0;                                      // RL5
         gang_d_ff    <= 1'b0;
         mode_lock_ff <= 1'b0;
         min_width_ff <= hpp_pkg::RST_MIN_WIDTH;
         inactive_ff  <= hpp_pkg::RST_INACTIVE;
         lockout_ff   <= hpp_pkg::RST_LOCKOUT;
      end else begin
         pwr_en_ff    <= nxt_pwr_en;
         chg_en_ff    <= nxt_chg_en;
         gang_ff      <= nxt_gang;
         gang_d_ff    <= gang_ff;
         mode_lock_ff <= nxt_mode_lock;
         min_width_ff <= nxt_min_width;
         inactive_ff  <= nxt_inactive;
         lockout_ff   <= nxt_lockout;
      end
   end

   // channel 0 swaps its pin source when the mode flips; that is treated
   // as a fresh power-on, so the old source's level is not filtered as a
   // fault (a one-step lockout may still end at the very next tick)
   wire logic mode_flip = gang_ff != gang_d_ff;

   // ----------------------------------------------------------------
   // millisecond tick
   // ----------------------------------------------------------------
   // one free-running tick serves the lockout and window timers: each is good to one step,
   // traded for a single counter instead of one per channel
   logic [TW-1:0] tick_cnt_ff;
   wire  logic    tick = tick_cnt_ff == TW'(TICK_CYCLES - 1);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) tick_cnt_ff <= '0;
      else          tick_cnt_ff <= tick ? '0 : tick_cnt_ff + TW'(1);
   end

   // ----------------------------------------------------------------
   // per channel: synchroniser, lockout and pulse filters
   // ----------------------------------------------------------------
   // channel 0 also serves the ganged pin; in ganged mode it follows
   // the OR of all power enables
   wire logic any_pwr = |pwr_en_ff;
   logic [NPORTS-1:0] ch_en;
   logic [NPORTS-1:0] ch_pin;
   logic [NPORTS-1:0] ch_oc;
   logic [NPORTS-1:0] samp_q;

   assign ch_en[0]  = gang_ff ? any_pwr : pwr_en_ff[0];               // RL2
   assign ch_pin[0] = gang_ff ? shared_power_pin_i : port_ctl_pin_i[0];
   if (NPORTS > 1) begin : g_rest
      assign ch_en[NPORTS-1:1]  = gang_ff ? '0 : pwr_en_ff[NPORTS-1:1];
      assign ch_pin[NPORTS-1:1] = port_ctl_pin_i[NPORTS-1:1];
   end

   for (genvar i = 0; i < NPORTS; i++) begin : g_ch
      logic       s1_ff, s2_ff, prev_ff, en_d_ff, armed_ff;
      logic [7:0] lock_ff, win_ff;
      logic [3:0] low_ms_ff;
      logic [TW-1:0] low_sub_ff;
      wire logic active = ch_en[i] && en_d_ff && !mode_flip && lock_ff == 8'h00; // RL16
      wire logic low    = active && !s2_ff;                           // RL9
      wire logic fall   = low && prev_ff;
      wire logic single = low && low_ms_ff >= min_width_ff;          // RL10
      wire logic dbl    = fall && armed_ff && win_ff != 8'h00;       // RL11
      assign ch_oc[i]  = single | dbl;
      assign samp_q[i] = s2_ff;
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            s1_ff      <= 1'b1;
            s2_ff      <= 1'b1;
            prev_ff    <= 1'b1;
            en_d_ff    <= 1'b0;
            armed_ff   <= 1'b0;
            lock_ff    <= 8'h00;
            win_ff     <= 8'h00;
            low_ms_ff  <= 4'h0;
            low_sub_ff <= '0;
         end else begin
            s1_ff   <= ch_pin[i];                                     // RL17
            s2_ff   <= s1_ff;                                         // RL17
            prev_ff <= active ? s2_ff : 1'b1;
            en_d_ff <= ch_en[i];
            // lockout restarts on every power-on edge and on every mode flip while powered; a disabled channel holds it at zero
            if (ch_en[i] && (!en_d_ff || mode_flip))                lock_ff <= lockout_ff;
            else if (!ch_en[i])                                     lock_ff <= 8'h00;
            else if (tick && lock_ff != 8'h00)                      lock_ff <= lock_ff - 8'h01;
            // the width count restarts on any high sample and saturates
            if (low) begin
               low_sub_ff <= (low_sub_ff == TW'(TICK_CYCLES - 1)) ? '0 : low_sub_ff + TW'(1);
               if (low_sub_ff == TW'(TICK_CYCLES - 1) && low_ms_ff != 4'hF)
                  low_ms_ff <= low_ms_ff + 4'h1;
            end else begin
               low_sub_ff <= '0;
               low_ms_ff  <= 4'h0;
            end
            // first low group opens the rolling window
            if (!active) begin
               armed_ff <= 1'b0;
               win_ff   <= 8'h00;
            end else if (fall && !armed_ff) begin
               armed_ff <= 1'b1;
               win_ff   <= inactive_ff;
            end else if (armed_ff && tick) begin
               if (win_ff <= 8'h01) armed_ff <= 1'b0;
               win_ff <= win_ff - 8'h01;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // overcurrent status: sticky, write one to clear, set wins
   // ----------------------------------------------------------------
   wire logic [NPORTS-1:0] oc_set = gang_ff ? {NPORTS{ch_oc[0]}} : ch_oc; // RL3
   wire logic [NPORTS-1:0] oc_clr = wr_ocst ? hwdata[NPORTS-1:0] : '0;
   wire logic [NPORTS-1:0] nxt_oc_stat = (oc_stat_ff & ~oc_clr) | oc_set;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) oc_stat_ff <= '0;
      else          oc_stat_ff <= nxt_oc_stat;
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   // the pad only ever drives zero, so o stays low; oe_n low means driving
   // ganged mode releases the port pins with no pull-up: the shared pin
   // alone carries power and sense then
   wire logic [NPORTS-1:0] nxt_drive = gang_ff ? '0 : ~pwr_en_ff;   // RL1
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_ctl_pin_o         <= '0;
         port_ctl_pin_oe_n      <= '0;
         port_ctl_pullup_en     <= '0;
         shared_power_pin_o     <= 1'b0;
         shared_power_pin_oe_n  <= 1'b0;
         shared_power_pullup_en <= 1'b0;
         chg_ack                <= '0;
         oc_flag                <= '0;
      end else begin
         port_ctl_pin_o         <= '0;
         port_ctl_pin_oe_n      <= ~nxt_drive;                        // RL6
         port_ctl_pullup_en     <= gang_ff ? '0 : pwr_en_ff;          // RL7
         shared_power_pin_o     <= 1'b0;
         shared_power_pin_oe_n  <= gang_ff & any_pwr;                 // RL6
         shared_power_pullup_en <= gang_ff & any_pwr;                 // RL7
         // acknowledge only; no charging current is sourced here
         chg_ack                <= chg_en_ff & pwr_en_ff;             // RL13
         oc_flag                <= nxt_oc_stat;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   // hrdata loads at the address phase and stands until the next read
   logic [31:0] nxt_rdata;
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (haddr[11:0])
         hpp_pkg::OFS_PWR_EN:    nxt_rdata[NPORTS-1:0] = nxt_pwr_en;
         hpp_pkg::OFS_MODE:      nxt_rdata[1:0] = {nxt_mode_lock, nxt_gang};
         hpp_pkg::OFS_CHG_EN:    nxt_rdata[NPORTS-1:0] = nxt_chg_en;
         hpp_pkg::OFS_MIN_WIDTH: nxt_rdata[3:0] = nxt_min_width;
         hpp_pkg::OFS_INACTIVE:  nxt_rdata[7:0] = nxt_inactive;
         hpp_pkg::OFS_LOCKOUT:   nxt_rdata[7:0] = nxt_lockout;
         hpp_pkg::OFS_OC_STATUS: nxt_rdata[NPORTS-1:0] = nxt_oc_stat;
         hpp_pkg::OFS_PIN_STATE: nxt_rdata[NPORTS-1:0] = samp_q;
         default:                nxt_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         // zero wait states: ready and OKAY always
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (addr_phase && !hwrite) hrdata <= nxt_rdata;
      end
   end
endmodule
`default_nettype wire

/* dv/hpp_sw_model.sv */
// external power switch model: open-drain fault output on each control pin
`default_nettype none
module hpp_sw_model #(
   parameter int N = 1
) (
   input  wire logic         clk,
   input  wire logic [N-1:0] oe_n,
   input  wire logic [N-1:0] pullup_en,
   input  wire logic [N-1:0] fault,
   output var  logic [N-1:0] pin
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [N-1:0] flip_ff = '0;
   // an undriven line with no pull-up must not settle to a lucky level
   always_ff @(posedge clk) flip_ff <= ~flip_ff;
   always_comb begin
      for (int i = 0; i < N; i++) begin
         pin[i] = !oe_n[i] ? 1'b0 : fault[i] ? 1'b0 : pullup_en[i] ? 1'b1 : flip_ff[i];
      end
   end
endmodule
`default_nettype wire

/* dv/hpp_port_power_assertions.sv */
// concurrent checks on pin control, charging indication and overcurrent flags
`default_nettype none
module hpp_port_power_assertions #(
   parameter int NPORTS      = 6,
   parameter int TICK_CYCLES = 40000
) (
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic              hreadyout,
   input wire logic              hresp,
   input wire logic [NPORTS-1:0] port_ctl_pin_i,
   input wire logic [NPORTS-1:0] port_ctl_pin_o,
   input wire logic [NPORTS-1:0] port_ctl_pin_oe_n,
   input wire logic [NPORTS-1:0] port_ctl_pullup_en,
   input wire logic              shared_power_pin_o,
   input wire logic              shared_power_pin_oe_n,
   input wire logic              shared_power_pullup_en,
   input wire logic [NPORTS-1:0] chg_ack,
   input wire logic [NPORTS-1:0] oc_flag
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   pin_zero_a: assert property (port_ctl_pin_o == '0 && !shared_power_pin_o)
      else $error("pin data not zero");
   off_pull_a: assert property ((port_ctl_pullup_en & ~port_ctl_pin_oe_n) == '0)
      else $error("pull-up on while driving low");
   gang_pull_a: assert property (shared_power_pullup_en == shared_power_pin_oe_n)
      else $error("shared pin pull-up and release differ");
   gang_excl_a: assert property (shared_power_pin_oe_n |-> port_ctl_pullup_en == '0)
      else $error("port pin pulled up in ganged mode");
   chg_pwr_a: assert property ((chg_ack & ~port_ctl_pin_oe_n & {NPORTS{!shared_power_pin_oe_n}}) == '0)
      else $error("charging ack on unpowered port");
   lock_quiet_a: assert property ($rose(port_ctl_pin_oe_n[0]) |=> (!$rose(oc_flag[0]))[*8])
      else $error("overcurrent right after power on");
   gang_all_a: assert property ($rose(oc_flag[0]) && shared_power_pin_oe_n |-> &oc_flag)
      else $error("ganged overcurrent not on all ports");
   oc_cause_a: assert property ($rose(oc_flag[0]) && !shared_power_pin_oe_n |->
      !$past(port_ctl_pin_i[0], 3) || !$past(port_ctl_pin_i[0], 4) || !$past(port_ctl_pin_i[0], 5))
      else $error("overcurrent without low pin");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus not ready or error response");
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench: register access, pin drive and overcurrent detection
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int N = 2;
   logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0]  haddr, hwdata, hrdata, q;
   logic [1:0]   htrans;
   logic [2:0]   hsize;
   logic [N-1:0] flt, pin_i, pin_o, oe_n, pu, chg_ack, oc_flag;
   logic         gflt, sh_i, sh_o, sh_oe_n, sh_pu;
   int           error_cnt, compares;
   hpp_port_power #(.NPORTS(N), .TICK_CYCLES(20)) uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .port_ctl_pin_i(pin_i), .port_ctl_pin_o(pin_o), .port_ctl_pin_oe_n(oe_n),
      .port_ctl_pullup_en(pu), .shared_power_pin_i(sh_i), .shared_power_pin_o(sh_o),
      .shared_power_pin_oe_n(sh_oe_n), .shared_power_pullup_en(sh_pu),
      .chg_ack(chg_ack), .oc_flag(oc_flag));
   hpp_sw_model #(.N(N)) u_sw (.clk(hclk), .oe_n(oe_n), .pullup_en(pu), .fault(flt), .pin(pin_i));
   hpp_sw_model #(.N(1)) u_gsw (.clk(hclk), .oe_n(sh_oe_n), .pullup_en(sh_pu), .fault(gflt),
      .pin(sh_i));
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   task automatic wrap_up;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // the master never assumes a latency: it polls ready under a bound
   task automatic wait_rdy;
      int n;
      @(posedge hclk);
      for (n = 0; hreadyout !== 1'b1 && n < 50; n++) @(posedge hclk);
      if (n == 50) begin
         error_cnt++;
         wrap_up();
      end
   endtask
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      chk(q, exp);
   endtask
   task automatic pulse(input int n);
      flt <= 2'h1;
      repeat (n) @(posedge hclk);
      flt <= 2'h0;
      repeat (8) @(posedge hclk);
   endtask
   initial begin
      {hresetn, hsel, hwrite, gflt} = 4'h0;
      {haddr, hwdata} = 64'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      flt = 2'h0;
      error_cnt = 0;
      compares = 0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      hsel <= 1'b1;
      chk(32'(oe_n), 32'h0);
      chk(32'(pu), 32'h0);
      @(posedge hclk);
      rd(hpp_pkg::OFS_MODE, 32'h0);
      rd(hpp_pkg::OFS_MIN_WIDTH, 32'h1);
      rd(hpp_pkg::OFS_INACTIVE, 32'h14);
      rd(hpp_pkg::OFS_LOCKOUT, 32'h0A);
      rd(12'h100, 32'h0);
      wr(hpp_pkg::OFS_MIN_WIDTH, 32'h9);
      rd(hpp_pkg::OFS_MIN_WIDTH, 32'h5);
      wr(hpp_pkg::OFS_MIN_WIDTH, 32'h0);
      wr(hpp_pkg::OFS_LOCKOUT, 32'h2);
      wr(hpp_pkg::OFS_INACTIVE, 32'h2);
      wr(hpp_pkg::OFS_CHG_EN, 32'h3);
      wr(hpp_pkg::OFS_PWR_EN, 32'h1);
      pulse(10);
      chk(32'(oe_n), 32'h1);
      chk(32'(pu), 32'h1);
      chk(32'(chg_ack), 32'h1);
      rd(hpp_pkg::OFS_PIN_STATE, 32'h1);
      repeat (60) @(posedge hclk);
      chk(32'(oc_flag), 32'h0);
      pulse(4);
      chk(32'(oc_flag), 32'h1);
      rd(hpp_pkg::OFS_OC_STATUS, 32'h1);
      wr(hpp_pkg::OFS_MIN_WIDTH, 32'h2);
      wr(hpp_pkg::OFS_OC_STATUS, 32'h3);
      repeat (80) @(posedge hclk);
      chk(32'(oc_flag), 32'h0);
      pulse(70);
      chk(32'(oc_flag), 32'h1);
      wr(hpp_pkg::OFS_OC_STATUS, 32'h3);
      repeat (80) @(posedge hclk);
      pulse(4);
      chk(32'(oc_flag), 32'h0);
      pulse(4);
      chk(32'(oc_flag), 32'h1);
      wr(hpp_pkg::OFS_OC_STATUS, 32'h3);
      wr(hpp_pkg::OFS_MODE, 32'h1);
      wr(hpp_pkg::OFS_PWR_EN, 32'h3);
      repeat (80) @(posedge hclk);
      chk(32'({sh_pu, sh_oe_n}), 32'h3);
      chk(32'(pu), 32'h0);
      gflt <= 1'b1;
      repeat (70) @(posedge hclk);
      gflt <= 1'b0;
      repeat (8) @(posedge hclk);
      chk(32'(oc_flag), 32'h3);
      wr(hpp_pkg::OFS_MODE, 32'h3);
      wr(hpp_pkg::OFS_MODE, 32'h0);
      rd(hpp_pkg::OFS_MODE, 32'h3);
      wr(hpp_pkg::OFS_PWR_EN, 32'h0);
      repeat (2) @(posedge hclk);
      chk(32'({sh_pu, sh_oe_n}), 32'h0);
      wrap_up();
   end
endmodule
bind hpp_port_power hpp_port_power_assertions #(.NPORTS(NPORTS), .TICK_CYCLES(TICK_CYCLES)) u_chk (
   .hclk, .hresetn, .hreadyout, .hresp, .port_ctl_pin_i, .port_ctl_pin_o, .port_ctl_pin_oe_n,
   .port_ctl_pullup_en, .shared_power_pin_o, .shared_power_pin_oe_n, .shared_power_pullup_en,
   .chg_ack, .oc_flag);
`default_nettype wire
